//--- dv/ipsc_far_end.sv
// stand-in for the external pins, on-chip sources and core
// assumes the bench calls its tasks from the clk domain
`timescale 1ns/10ps
`default_nettype none
module ipsc_far_end (
  input wire logic clk,
  input wire logic nmi_req,
  output ipsc_pkg::ipsc_pins_t pins,
  output ipsc_pkg::ipsc_periph_t periph,
  output logic standby,
  output logic block_bit,
  output logic nmi_ack
);
  initial
  begin
    pins = '1;
    periph = '0;
    standby = 1'b0;
    block_bit = 1'b0;
    nmi_ack = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // core acks nmi_req on alternate cycles while it is held
  always @(posedge clk)
    nmi_ack <= nmi_req & ~nmi_ack;
  task automatic set_pins(input ipsc_pkg::ipsc_pins_t v);
    @(posedge clk);
    pins <= v;
  endtask
  task automatic set_periph(input ipsc_pkg::ipsc_periph_t v);
    @(posedge clk);
    periph <= v;
  endtask
  task automatic set_core(input logic s, input logic b);
    @(posedge clk);
    standby <= s;
    block_bit <= b;
  endtask
endmodule // ipsc_far_end
`default_nettype wire

//--- dv/tb.sv
// self-checking bench for the interrupt priority and sense block
// assumes the far-end model drives all pin and source inputs
`timescale 1ns/10ps
`default_nettype none
`include "ipsc_regs.svh"
module tb;
  logic clk;
  logic rst;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  ipsc_pkg::ipsc_pins_t pins;
  ipsc_pkg::ipsc_pins_t p;
  ipsc_pkg::ipsc_periph_t periph;
  logic standby;
  logic block_bit;
  logic nmi_ack;
  logic nmi_req;
  ipsc_pkg::ipsc_int_t int_out;
  int fails;
  int cmp_count;
  int l;
  integer seed;
  logic [15:0] rm [7];

  ipsc_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pins(pins), .periph(periph),
    .standby(standby), .block_bit(block_bit), .nmi_ack(nmi_ack),
    .nmi_req(nmi_req), .int_out(int_out));
  ipsc_far_end far (.clk(clk), .nmi_req(nmi_req), .pins(pins),
    .periph(periph), .standby(standby), .block_bit(block_bit),
    .nmi_ack(nmi_ack));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_int(input int lv);
    repeat (6) @(posedge clk);
    #1;
    chk("req", 16'(lv != 0), 16'(int_out.req));
    if (lv != 0)
    begin
      chk("level", 16'(lv), 16'(int_out.level));
      chk("code", 16'(12'h200 + 12'((15 - lv) * 32)), 16'(int_out.code));
    end
  endtask
  task automatic wait_nmi();
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      #1;
      if (nmi_req === 1'b1)
      begin
        cmp_count++;
        return;
      end
    end
    fails++;
    $display("mismatch nmi_req exp 1 got %b", nmi_req);
    stop_test();
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic chk_nmi(input logic e);
    repeat (6) @(posedge clk);
    #1;
    chk("nmi_req", 16'(e), 16'(nmi_req));
  endtask
  // software keeps reserved fields zero and never uses sense code 11
  function automatic logic [15:0] legal(input logic [3:0] a, input logic [15:0] d);
    legal = d;
    if (a == `IPSC_OFS_PRIO_B)
      legal = d & `IPSC_PRIO_B_RSVD_MASK;
    if (a == `IPSC_OFS_NMI_CTRL)
      legal = d & 16'h0100;
    if (a == `IPSC_OFS_EXT_CTRL)
      for (int i = 0; i < 6; i++)
        if (d[2*i +: 2] == 2'h3)
          legal[2*i + 1] = 1'b0;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == `IPSC_OFS_PRIO_B)
      d &= 16'hFFF0;
    if (a == `IPSC_OFS_NMI_CTRL)
      d &= 16'h0100;
    if (!a[0] && a < 4'hE)
      rm[a / 2] = d;
  endtask
  function automatic logic [15:0] exp_rd(input logic [3:0] a);
    if (a[0] || a > 4'hC)
      return 16'h0000;
    if (a == `IPSC_OFS_NMI_CTRL)
      return rm[5] | {pins.nmi, 15'h0000};
    return rm[a / 2];
  endfunction
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg%0h", a), e, reg_rdata);
  endtask
  task automatic rd_all();
    for (int a = 0; a < 16; a++)
      rd_chk(4'(a), exp_rd(4'(a)));
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (rm[i])
      rm[i] = 16'h0000;
    rm[6] = `IPSC_EXT_CTRL_RESET;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    #2000000;
    fails++;
    stop_test();
  end
  initial
  begin
    seed = 14746;
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fails = 0;
    cmp_count = 0;
    do_reset();
    rd_all();
    for (int a = 0; a < 16; a++)
      wr(4'(a), legal(4'(a), 16'($random(seed))));
    rd_all();
    p = '1;
    p.nmi = 1'b0;
    far.set_pins(p);
    do_reset();
    wait_nmi();
    rd_all();
    wr(`IPSC_OFS_NMI_CTRL, 16'h0100);
    far.set_pins('1);
    wait_nmi();
    // each request pin in low-level sense on its own field
    for (int k = 0; k < 6; k++)
    begin
      l = 1 + {$random(seed)} % 15;
      wr(`IPSC_OFS_EXT_CTRL, 16'(2 << (2 * k)));
      wr(k < 4 ? `IPSC_OFS_PRIO_C : `IPSC_OFS_PRIO_D, 16'(l << (4 * (k % 4))));
      p = '1;
      p.ext_req[k] = 1'b0;
      far.set_pins(p);
      chk_int(l);
      far.set_pins('1);
      chk_int(0);
    end
    // pin 5 through falling, low-level and rising sense
    wr(`IPSC_OFS_EXT_CTRL, 16'h0000);
    wr(`IPSC_OFS_PRIO_D, 16'h0050);
    p = '1;
    p.ext_req[5] = 1'b0;
    far.set_pins(p);
    chk_int(5);
    rd_chk(`IPSC_OFS_EDGE_PEND, 16'h0020);
    wr(`IPSC_OFS_EDGE_PEND, 16'h001F);
    chk_int(0);
    wr(`IPSC_OFS_EXT_CTRL, 16'h0800);
    chk_int(5);
    wr(`IPSC_OFS_PRIO_D, 16'h0000);
    chk_int(0);
    wr(`IPSC_OFS_EXT_CTRL, 16'h0400);
    wr(`IPSC_OFS_PRIO_D, 16'h0050);
    far.set_pins('1);
    chk_int(5);
    wr(`IPSC_OFS_EDGE_PEND, 16'h001F);
    far.set_pins(p);
    chk_int(0);
    // encoded level mode with and without the secondary pins
    wr(`IPSC_OFS_PRIO_D, 16'h0000);
    wr(`IPSC_OFS_EXT_CTRL, 16'h4000);
    p = '1;
    p.ext_req[3:0] = ~4'h9;
    p.secondary = ~4'hC;
    far.set_pins(p);
    chk_int(9);
    wr(`IPSC_OFS_EXT_CTRL, 16'h5000);
    chk_int(12);
    p.secondary = ~4'h3;
    far.set_pins(p);
    chk_int(9);
    far.set_pins('1);
    // on-chip source against mask-all on nmi low
    wr(`IPSC_OFS_EXT_CTRL, 16'h0000);
    wr(`IPSC_OFS_PRIO_A, 16'hA000);
    rd_chk(`IPSC_OFS_PRIO_A, 16'hA000);
    far.set_periph(13'h1000);
    chk_int(10);
    wr(`IPSC_OFS_EXT_CTRL, 16'h8000);
    p = '1;
    p.nmi = 1'b0;
    far.set_pins(p);
    chk_int(0);
    rd_chk(`IPSC_OFS_NMI_CTRL, exp_rd(`IPSC_OFS_NMI_CTRL));
    wr(`IPSC_OFS_EXT_CTRL, 16'h0000);
    chk_int(10);
    // nmi held off by the block bit until accepted
    far.set_core(1'b0, 1'b1);
    far.set_pins('1);
    chk_nmi(1'b0);
    wr(`IPSC_OFS_EXT_CTRL, 16'h2000);
    wait_nmi();
    // nmi held off in standby while mask-all is set
    far.set_core(1'b1, 1'b0);
    wr(`IPSC_OFS_EXT_CTRL, 16'h8000);
    wr(`IPSC_OFS_NMI_CTRL, 16'h0000);
    far.set_pins(p);
    chk_nmi(1'b0);
    rd_chk(`IPSC_OFS_PRIO_A, 16'hA000);
    wr(`IPSC_OFS_EXT_CTRL, 16'h0000);
    wait_nmi();
    stop_test();
  end
endmodule // tb
`default_nettype wire

//--- logic/ipsc_pkg.sv
// types shared by the interrupt priority and sense control block
// assumes users name every item with the package scope
`default_nettype none
package ipsc_pkg;
  typedef struct packed {
    logic nmi;
    logic [5:0] ext_req;
    logic [3:0] secondary;
  } ipsc_pins_t;

  typedef struct packed {
    logic timer0;
    logic timer1;
    logic timer2;
    logic clock;
    logic watchdog;
    logic refresh;
    logic serial0;
    logic pin_grp0;
    logic pin_grp1;
    logic dma;
    logic infrared;
    logic fifo_serial;
    logic converter;
  } ipsc_periph_t;

  typedef struct packed {
    logic req;
    logic [3:0] level;
    logic [11:0] code;
  } ipsc_int_t;

  typedef enum logic [1:0] {
    IPSC_FALL = 2'b00,
    IPSC_RISE = 2'b01,
    IPSC_LOW = 2'b10,
    IPSC_RSVD = 2'b11
  } ipsc_sense_t;
endpackage
`default_nettype wire

//--- logic/ipsc_regs.svh
// register map, field positions, reset values and codes of the
// interrupt priority and sense control block
// assumes a 16-bit register port addressed by a 4-bit offset
`ifndef IPSC_REGS_SVH
`define IPSC_REGS_SVH

`define IPSC_OFS_PRIO_A 4'h0
`define IPSC_OFS_PRIO_B 4'h2
`define IPSC_OFS_PRIO_C 4'h4
`define IPSC_OFS_PRIO_D 4'h6
`define IPSC_OFS_PRIO_E 4'h8
`define IPSC_OFS_NMI_CTRL 4'hA
`define IPSC_OFS_EXT_CTRL 4'hC
`define IPSC_OFS_EDGE_PEND 4'hE

`define IPSC_PRIO_RESET 16'h0000
`define IPSC_EXT_CTRL_RESET 16'h4000
`define IPSC_PRIO_B_RSVD_MASK 16'hFFF0
`define IPSC_NMI_CTRL_RSVD_MASK 16'h7EFF

`define IPSC_NMI_LEVEL_BIT 15
`define IPSC_NMI_EDGE_BIT 8
`define IPSC_MAI_BIT 15
`define IPSC_ENC_MODE_BIT 14
`define IPSC_BLK_ACCEPT_BIT 13
`define IPSC_SEC_EN_BIT 12

`define IPSC_SENSE_FALL 2'h0
`define IPSC_SENSE_RISE 2'h1
`define IPSC_SENSE_LOW 2'h2

`define IPSC_CODE_LEVEL15 12'h200
`define IPSC_CODE_STEP 12'h020
`define IPSC_LEVEL_MAX 4'hF

`endif

//--- logic/ipsc_top.sv
// interrupt priority and sense control: registers, pin sense, masking
// assumes a same-clock register master and asynchronous external pins
//
// Functional notes
// - five priority registers, four 4-bit fields each, levels 0 to 15.
// - a group with priority zero is masked and never presented.
// - fixed mapping of source groups to priority fields.
// - reserved low field of register B reads zero; software writes zero.
// - priority registers 16-bit read/write, reset to zero, kept in standby.
// - nmi control bit 15 shows live nmi pin level, not writable.
// - nmi control bit 8 picks nmi edge: 0 falling, 1 rising.
// - nmi control bits 14:9 and 7:0 read zero.
// - nmi control resets to 0000 or 8000 following the pin.
// - external request control resets to 4000, kept in standby.
// - mask-all bit masks every request while nmi pin is low.
// - mask-all bit also masks nmi while in standby.
// - encoded mode bit turns request pins 3:0 into an encoded level.
// - block accept bit lets nmi through while block bit is set.
// - secondary level pins enabled by bit 12, only in encoded mode.
// - sense code 00 falling, 01 rising, 10 low level, 11 reserved.
// - sense fields for pins 5 to 0 at bits 11:10 down to 1:0.
// - with secondary enabled, effective level is the higher encoded input.
// - event code 200 for level 15, plus 20 per level down.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ipsc_regs.svh"

module ipsc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire ipsc_pkg::ipsc_pins_t pins,
  input wire ipsc_pkg::ipsc_periph_t periph,
  input wire logic standby,
  input wire logic block_bit,
  input wire logic nmi_ack,
  output logic nmi_req,
  output ipsc_pkg::ipsc_int_t int_out
);

  ////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [11:0] code_of(input logic [3:0] lvl);
    code_of = `IPSC_CODE_LEVEL15 + 12'(`IPSC_LEVEL_MAX - lvl) * `IPSC_CODE_STEP;
  endfunction

  function automatic logic [3:0] max4(input logic [3:0] a, input logic [3:0] b);
    max4 = (a > b) ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] prio_a_ff;
  logic [15:0] prio_b_ff;
  logic [15:0] prio_c_ff;
  logic [15:0] prio_d_ff;
  logic [15:0] prio_e_ff;
  logic nmi_edge_select_ff;
  logic [15:0] ext_ctrl_ff;
  logic [5:0] edge_pend_ff;
  logic nmi_pend_ff;
  logic [15:0] rdata_ff;
  logic nmi_req_ff;
  ipsc_pkg::ipsc_int_t int_ff;

  // synchronisers: stage 1 feeds only stage 2
  logic [10:0] pin_s1_ff;
  logic [10:0] pin_s2_ff;
  logic [6:0] edge_prev_ff;

  logic global_mask_on_nmi_low;
  logic encoded_level_mode;
  logic block_bit_nmi_accept;
  logic secondary_level_pins_enable;
  logic nmi_pin_level;
  logic [5:0] ext_s;
  logic [3:0] sec_s;

  assign global_mask_on_nmi_low = ext_ctrl_ff[`IPSC_MAI_BIT];
  assign encoded_level_mode = ext_ctrl_ff[`IPSC_ENC_MODE_BIT];
  assign block_bit_nmi_accept = ext_ctrl_ff[`IPSC_BLK_ACCEPT_BIT];
  assign secondary_level_pins_enable = ext_ctrl_ff[`IPSC_SEC_EN_BIT];
  assign nmi_pin_level = pin_s2_ff[10];
  assign ext_s = pin_s2_ff[9:4];
  assign sec_s = pin_s2_ff[3:0];

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge history
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_s1_ff <= 11'h7FF;
      pin_s2_ff <= 11'h7FF;
      edge_prev_ff <= 7'h7F;
    end
    else
    begin
      pin_s1_ff <= {pins.nmi, pins.ext_req, pins.secondary};
      pin_s2_ff <= pin_s1_ff;
      edge_prev_ff <= pin_s2_ff[10:4];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register writes
  logic wr_a;
  logic wr_b;
  logic wr_c;
  logic wr_d;
  logic wr_e;
  logic wr_nmi;
  logic wr_ext;
  logic wr_pend;

  assign wr_a = reg_wr && reg_addr == `IPSC_OFS_PRIO_A;
  assign wr_b = reg_wr && reg_addr == `IPSC_OFS_PRIO_B;
  assign wr_c = reg_wr && reg_addr == `IPSC_OFS_PRIO_C;
  assign wr_d = reg_wr && reg_addr == `IPSC_OFS_PRIO_D;
  assign wr_e = reg_wr && reg_addr == `IPSC_OFS_PRIO_E;
  assign wr_nmi = reg_wr && reg_addr == `IPSC_OFS_NMI_CTRL;
  assign wr_ext = reg_wr && reg_addr == `IPSC_OFS_EXT_CTRL;
  assign wr_pend = reg_wr && reg_addr == `IPSC_OFS_EDGE_PEND;

  // standby has no effect on the priority and control registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prio_a_ff <= `IPSC_PRIO_RESET;
      prio_b_ff <= `IPSC_PRIO_RESET;
      prio_c_ff <= `IPSC_PRIO_RESET;
      prio_d_ff <= `IPSC_PRIO_RESET;
      prio_e_ff <= `IPSC_PRIO_RESET;
    end
    else
    begin
      if (wr_a)
        prio_a_ff <= reg_wdata;
      if (wr_b)
        prio_b_ff <= reg_wdata & `IPSC_PRIO_B_RSVD_MASK;
      if (wr_c)
        prio_c_ff <= reg_wdata;
      if (wr_d)
        prio_d_ff <= reg_wdata;
      if (wr_e)
        prio_e_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      nmi_edge_select_ff <= 1'b0;
      ext_ctrl_ff <= `IPSC_EXT_CTRL_RESET;
    end
    else
    begin
      if (wr_nmi)
        nmi_edge_select_ff <= reg_wdata[`IPSC_NMI_EDGE_BIT];
      if (wr_ext)
        ext_ctrl_ff <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin sense
  logic nmi_edge;
  logic [5:0] ext_edge;
  logic [5:0] ext_pend;
  logic [3:0] enc_level;

  assign nmi_edge = nmi_edge_select_ff ? (nmi_pin_level && !edge_prev_ff[6])
                                       : (!nmi_pin_level && edge_prev_ff[6]);

  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      case (ipsc_pkg::ipsc_sense_t'(ext_ctrl_ff[2*i +: 2]))
        ipsc_pkg::IPSC_FALL:
        begin
          ext_edge[i] = !ext_s[i] && edge_prev_ff[i];
          ext_pend[i] = edge_pend_ff[i];
        end
        ipsc_pkg::IPSC_RISE:
        begin
          ext_edge[i] = ext_s[i] && !edge_prev_ff[i];
          ext_pend[i] = edge_pend_ff[i];
        end
        ipsc_pkg::IPSC_LOW:
        begin
          ext_edge[i] = 1'b0;
          ext_pend[i] = !ext_s[i];
        end
        default:
        begin
          ext_edge[i] = 1'b0;
          ext_pend[i] = 1'b0;
        end
      endcase
      if (encoded_level_mode && i < 4)
      begin
        ext_edge[i] = 1'b0;
        ext_pend[i] = 1'b0;
      end
    end
  end

  // encoded pins are active low: all-low means level 15
  always_comb
  begin
    enc_level = ~ext_s[3:0];
    if (secondary_level_pins_enable)
      enc_level = max4(~ext_s[3:0], ~sec_s);
    if (!encoded_level_mode)
      enc_level = 4'h0;
  end

  // edge flags: write 0 clears, write 1 keeps; a new edge wins
  always_ff @(posedge clk)
  begin
    if (rst)
      edge_pend_ff <= 6'h00;
    else
      edge_pend_ff <= ((wr_pend ? (edge_pend_ff & reg_wdata[5:0]) : edge_pend_ff)
                       | ext_edge);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      nmi_pend_ff <= 1'b0;
    else
      nmi_pend_ff <= (nmi_pend_ff && !nmi_ack) || nmi_edge;
  end

  ////////////////////////////////////////////////////////////////////
  // priority selection
  logic [18:0] src_pend;
  logic [75:0] src_prio;
  logic [3:0] best;
  logic mask_all;
  logic nmi_blocked;

  assign src_pend = {periph.timer0, periph.timer1, periph.timer2, periph.clock,
                     periph.watchdog, periph.refresh, periph.serial0,
                     ext_pend[3], ext_pend[2], ext_pend[1], ext_pend[0],
                     periph.pin_grp0, periph.pin_grp1, ext_pend[5], ext_pend[4],
                     periph.dma, periph.infrared, periph.fifo_serial, periph.converter};
  assign src_prio = {prio_a_ff, prio_b_ff[15:4], prio_c_ff, prio_d_ff, prio_e_ff};

  always_comb
  begin
    best = enc_level;
    for (int i = 0; i < 19; i++)
      if (src_pend[i] && src_prio[4*i +: 4] > best)
        best = src_prio[4*i +: 4];
  end

  assign mask_all = global_mask_on_nmi_low && !nmi_pin_level;
  assign nmi_blocked = (block_bit && !block_bit_nmi_accept)
                       || (standby && global_mask_on_nmi_low);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      int_ff <= '0;
      nmi_req_ff <= 1'b0;
    end
    else
    begin
      int_ff.req <= best != 4'h0 && !mask_all;
      int_ff.level <= best;
      int_ff.code <= code_of(best);
      nmi_req_ff <= nmi_pend_ff && !nmi_blocked;
    end
  end

  assign int_out = int_ff;
  assign nmi_req = nmi_req_ff;

  ////////////////////////////////////////////////////////////////////
  // register reads, data in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_ff <= 16'h0000;
    else if (reg_rd)
      case (reg_addr)
        `IPSC_OFS_PRIO_A: rdata_ff <= prio_a_ff;
        `IPSC_OFS_PRIO_B: rdata_ff <= prio_b_ff & `IPSC_PRIO_B_RSVD_MASK;
        `IPSC_OFS_PRIO_C: rdata_ff <= prio_c_ff;
        `IPSC_OFS_PRIO_D: rdata_ff <= prio_d_ff;
        `IPSC_OFS_PRIO_E: rdata_ff <= prio_e_ff;
        `IPSC_OFS_NMI_CTRL: rdata_ff <= {nmi_pin_level, 6'h00, nmi_edge_select_ff, 8'h00};
        `IPSC_OFS_EXT_CTRL: rdata_ff <= ext_ctrl_ff;
        `IPSC_OFS_EDGE_PEND: rdata_ff <= {10'h000, edge_pend_ff};
        default: rdata_ff <= 16'h0000;
      endcase
    else
      rdata_ff <= 16'h0000;
  end

  assign reg_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////
  // checks
  sequence s_read_of(logic [3:0] ofs);
    reg_rd && reg_addr == ofs;
  endsequence

  property p_zero_masked;
    @(posedge clk) disable iff (rst)
      int_out.req |-> int_out.level != 4'h0;
  endproperty
  a_zero_masked: assert property (p_zero_masked)
    else $error("request presented at level zero");
  property p_prio_b_rsvd;
    @(posedge clk) disable iff (rst)
      s_read_of(`IPSC_OFS_PRIO_B) |=> reg_rdata[3:0] == 4'h0;
  endproperty
  a_prio_b_rsvd: assert property (p_prio_b_rsvd)
    else $error("reserved priority field not zero");

  property p_nmi_ctrl_read;
    @(posedge clk) disable iff (rst)
      s_read_of(`IPSC_OFS_NMI_CTRL) |=>
        (reg_rdata & `IPSC_NMI_CTRL_RSVD_MASK) == 16'h0000
        && reg_rdata[15] == $past(nmi_pin_level);
  endproperty
  a_nmi_ctrl_read: assert property (p_nmi_ctrl_read)
    else $error("nmi control read wrong");
  property p_prio_write;
    @(posedge clk) disable iff (rst)
      wr_a ##1 !reg_wr ##1 s_read_of(`IPSC_OFS_PRIO_A) |=>
        reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_prio_write: assert property (p_prio_write)
    else $error("priority write not read back");

  property p_ext_ctrl_reset;
    @(posedge clk) rst |=> ext_ctrl_ff == `IPSC_EXT_CTRL_RESET && prio_a_ff == 16'h0000;
  endproperty
  a_ext_ctrl_reset: assert property (p_ext_ctrl_reset)
    else $error("reset value wrong");
  property p_mask_all;
    @(posedge clk) disable iff (rst)
      mask_all |=> !int_out.req;
  endproperty
  a_mask_all: assert property (p_mask_all)
    else $error("request passed while masked by nmi low");
  property p_nmi_standby;
    @(posedge clk) disable iff (rst)
      standby && global_mask_on_nmi_low |=> !nmi_req;
  endproperty
  a_nmi_standby: assert property (p_nmi_standby)
    else $error("nmi passed in standby while masked");
  property p_nmi_block;
    @(posedge clk) disable iff (rst)
      block_bit && !block_bit_nmi_accept |=> !nmi_req;
  endproperty
  a_nmi_block: assert property (p_nmi_block)
    else $error("nmi passed while block bit set");

  sequence s_nmi_rise;
    nmi_edge_select_ff && !edge_prev_ff[6] && nmi_pin_level;
  endsequence
  property p_nmi_edge;
    @(posedge clk) disable iff (rst)
      s_nmi_rise |=> nmi_pend_ff;
  endproperty
  a_nmi_edge: assert property (p_nmi_edge)
    else $error("nmi rising edge not caught");

  property p_code;
    @(posedge clk) disable iff (rst)
      int_out.req && int_out.level == 4'h1 |-> int_out.code == 12'h3C0;
  endproperty
  a_code: assert property (p_code)
    else $error("event code for level one wrong");
  property p_enc_max;
    @(posedge clk) disable iff (rst)
      encoded_level_mode && secondary_level_pins_enable && !mask_all
      && sec_s != 4'hF |=> int_out.req && int_out.level >= ~$past(sec_s);
  endproperty
  a_enc_max: assert property (p_enc_max)
    else $error("secondary level not taken as higher");

endmodule // ipsc_top

`default_nettype wire
